// ---- rtl/flash_pkg.sv ----
// Purpose: shared constants and types for the serial flash device and its host
// Assumes: 250 MHz system clock on both ends
// Notes: opcode values and host register offsets are fixed here once
package flash_pkg;
  // clock rate and timing figures
  localparam int CLK_MHZ = 250;
  localparam int LOCKOUT_TIME_MS = 10;
  localparam int LOCKOUT_CYCLES = LOCKOUT_TIME_MS * CLK_MHZ * 1000;
  localparam int VSL_TIME_US = 30;
  localparam int VSL_CYCLES = VSL_TIME_US * CLK_MHZ;
  localparam int ERASE_CYCLES_DEF = 1000;
  localparam int SLEEP_CYCLES_DEF = 40;
  localparam int WAKE_CYCLES_DEF = 40;
  localparam int SCLK_HALF_DEF = 4;
  localparam int DESEL_CYCLES = 8;
  // instruction codes
  localparam logic [7:0] OP_WRITE_PERMIT = 8'h06;
  localparam logic [7:0] OP_ARRAY_ERASE = 8'hc7;
  localparam logic [7:0] OP_SLEEP = 8'hb9;
  localparam logic [7:0] OP_WAKE = 8'hab;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  // status byte layout and values
  localparam int STAT_CYCLE_BIT = 0;
  localparam int STAT_PERMIT_BIT = 1;
  localparam int STAT_PROT_LSB = 2;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // host register map, word aligned
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam int CMD_READ_BIT = 8;
  localparam int HST_BUSY_BIT = 0;
  localparam int HST_REFUSED_BIT = 1;
  localparam int HST_ASLEEP_BIT = 2;
  localparam int HST_RX_LSB = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  // device power state, one-hot
  typedef enum logic [4:0] {
    DEV_STANDBY = 5'b00001,
    DEV_ERASE = 5'b00010,
    DEV_SLEEP_ENTER = 5'b00100,
    DEV_SLEEP = 5'b01000,
    DEV_WAKE = 5'b10000
  } dev_state_t;
  // host frame state, one-hot
  typedef enum logic [3:0] {
    HOST_IDLE = 4'b0001,
    HOST_SHIFT = 4'b0010,
    HOST_END = 4'b0100,
    HOST_GAP = 4'b1000
  } host_state_t;
endpackage

// ---- rtl/flash_link_if.sv ----
// Purpose: serial link between host controller and flash device
// Assumes: return data line idles high when undriven
// Notes: line level of the return data is resolved here from its enable
interface flash_link_if;
  logic cs_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;
  // pulled-up return line
  assign miso_line = miso_oe ? miso : 1'b1;
  modport dev (input cs_n, input sclk, input mosi, output miso, output miso_oe);
  modport host (output cs_n, output sclk, output mosi, input miso_line);
endinterface

// ---- rtl/sync2.sv ----
// Purpose: two-stage synchroniser for pins from another clock domain
// Assumes: inputs are quasi-static levels relative to mclk_in
// Notes: the first stage feeds only the second
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta;

  // two flops in series
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta <= INIT;
      q_out <= INIT;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end
endmodule

// ---- rtl/flash_dev.sv ----
// Purpose: flash device end: array erase, deep sleep, wake, power-up gating
// Assumes: rstn_in is the on-chip supply reset; link pins are asynchronous
// Notes: array is a small flop model; lock registers hold their power-up value
module flash_dev
  import flash_pkg::*;
#(
  parameter int ERASE_CYCLES = ERASE_CYCLES_DEF,
  parameter int SLEEP_CYCLES = SLEEP_CYCLES_DEF,
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF,
  parameter int LOCKOUT = LOCKOUT_CYCLES,
  parameter int ARRAY_BYTES = 16,
  parameter int SECTORS = 4,
  parameter int AW = $clog2(ARRAY_BYTES),
  parameter int SW = $clog2(SECTORS)
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  flash_link_if.dev link,
  input wire logic [2:0] protect_level_in,
  input wire logic prog_we_in,
  input wire logic [AW-1:0] prog_addr_in,
  input wire logic [7:0] prog_data_in,
  input wire logic [AW-1:0] peek_addr_in,
  output logic [7:0] peek_data_out,
  input wire logic [SW-1:0] lock_sel_in,
  output logic [7:0] lock_reg_out,
  output logic cycle_active_out,
  output logic write_permit_out,
  output logic deep_sleep_out,
  output logic lockout_out
);
  dev_state_t state;
  logic [2:0] pins;
  logic s_cs_n, s_sclk, s_mosi;
  logic cs_q, sclk_q;
  logic [3:0] bit_cnt;
  logic [7:0] shift;
  logic [7:0] out_sh;
  logic reading;
  logic [31:0] timer;
  logic [31:0] lock_cnt;
  logic lockout;
  logic write_permit_latch;
  logic [7:0] mem [ARRAY_BYTES];
  logic [SECTORS-1:0] write_lock;
  logic [SECTORS-1:0] lock_down;

  // pins pass two flops before use
  sync2 #(.W(3), .INIT(3'b100)) u_sync (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .d_in({link.cs_n, link.sclk, link.mosi}),
    .q_out(pins)
  );
  assign s_cs_n = pins[2];
  assign s_sclk = pins[1];
  assign s_mosi = pins[0];

  // edge and instruction decode
  wire sclk_rise = s_sclk & ~sclk_q & ~s_cs_n;
  wire sclk_fall = ~s_sclk & sclk_q & ~s_cs_n;
  wire cs_rise = s_cs_n & ~cs_q;
  wire exact8 = cs_rise && (bit_cnt == 4'd8);
  wire standby = (state == DEV_STANDBY);
  wire asleep = (state == DEV_SLEEP_ENTER) || (state == DEV_SLEEP) || (state == DEV_WAKE);
  wire protected_any = |protect_level_in;
  wire go_permit = exact8 && (shift == OP_WRITE_PERMIT) && standby && !lockout;
  wire go_erase = exact8 && (shift == OP_ARRAY_ERASE) && standby && write_permit_latch && !protected_any && !lockout;
  wire go_sleep = exact8 && (shift == OP_SLEEP) && standby;
  wire go_wake = exact8 && (shift == OP_WAKE) && (state == DEV_SLEEP);
  wire timer_done = (timer == 32'd0);
  wire status_op = (shift == OP_STATUS_READ) && !asleep && (bit_cnt == 4'd8);
  wire [7:0] status_byte = {3'b000, protect_level_in, write_permit_latch, (state == DEV_ERASE)};

  // edge history of the synchronised pins
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_q <= s_cs_n;
      sclk_q <= s_sclk;
    end
  end

  // instruction shifter, count saturates to flag extra clocks
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_cnt <= 4'd0;
      shift <= 8'h00;
    end else if (s_cs_n) begin
      bit_cnt <= 4'd0;
    end else if (sclk_rise) begin
      if (bit_cnt < 4'd8) begin
        shift <= {shift[6:0], s_mosi};
      end
      if (bit_cnt != 4'hf) begin
        bit_cnt <= bit_cnt + 4'd1;
      end
    end
  end

  // status byte out on falling clock after the opcode
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reading <= 1'b0;
      out_sh <= STATUS_RESET;
      link.miso <= 1'b0;
      link.miso_oe <= 1'b0;
    end else if (s_cs_n) begin
      reading <= 1'b0;
      link.miso_oe <= 1'b0;
    end else if (sclk_fall) begin
      if (status_op) begin
        reading <= 1'b1;
        out_sh <= {status_byte[6:0], 1'b0};
        link.miso <= status_byte[7];
        link.miso_oe <= 1'b1;
      end else if (reading) begin
        out_sh <= {out_sh[6:0], 1'b0};
        link.miso <= out_sh[7];
      end
    end
  end

  // write lockout after supply reset release
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      lock_cnt <= 32'd0;
      lockout <= 1'b1;
    end else if (lockout) begin
      lock_cnt <= lock_cnt + 32'd1;
      if (lock_cnt == 32'(LOCKOUT - 1)) begin
        lockout <= 1'b0;
      end
    end
  end

  // power state machine with self-timed delays
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= DEV_STANDBY;
      timer <= 32'd0;
    end else begin
      case (state)
        DEV_STANDBY: begin
          if (go_erase) begin
            state <= DEV_ERASE;
            timer <= 32'(ERASE_CYCLES - 1);
          end else if (go_sleep) begin
            state <= DEV_SLEEP_ENTER;
            timer <= 32'(SLEEP_CYCLES - 1);
          end
        end
        DEV_ERASE: begin
          if (timer_done) state <= DEV_STANDBY;
          else timer <= timer - 32'd1;
        end
        DEV_SLEEP_ENTER: begin
          if (timer_done) state <= DEV_SLEEP;
          else timer <= timer - 32'd1;
        end
        DEV_SLEEP: begin
          if (go_wake) begin
            state <= DEV_WAKE;
            timer <= 32'(WAKE_CYCLES - 1);
          end
        end
        DEV_WAKE: begin
          if (timer_done) state <= DEV_STANDBY;
          else timer <= timer - 32'd1;
        end
        default: state <= DEV_STANDBY;
      endcase
    end
  end

  // write-permit latch: set by decode, cleared as erase starts
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      write_permit_latch <= 1'b0;
    end else if (go_erase) begin
      write_permit_latch <= 1'b0;
    end else if (go_permit) begin
      write_permit_latch <= 1'b1;
    end
  end

  // array model: program clears bits, completed erase sets all
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < ARRAY_BYTES; i++) mem[i] <= ERASED_BYTE;
    end else if ((state == DEV_ERASE) && timer_done) begin
      for (int i = 0; i < ARRAY_BYTES; i++) mem[i] <= ERASED_BYTE;
    end else if (prog_we_in && standby) begin
      mem[prog_addr_in] <= mem[prog_addr_in] & prog_data_in;
    end
  end

  // per-sector lock bits keep their power-up value here
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      write_lock <= '0;
      lock_down <= '0;
    end else begin
      write_lock <= write_lock;
      lock_down <= lock_down;
    end
  end

  // registered outputs
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      peek_data_out <= ERASED_BYTE;
      lock_reg_out <= 8'h00;
      cycle_active_out <= 1'b0;
      write_permit_out <= 1'b0;
      deep_sleep_out <= 1'b0;
      lockout_out <= 1'b1;
    end else begin
      peek_data_out <= mem[peek_addr_in];
      lock_reg_out <= {6'h00, lock_down[lock_sel_in], write_lock[lock_sel_in]};
      cycle_active_out <= (state == DEV_ERASE);
      write_permit_out <= write_permit_latch;
      deep_sleep_out <= (state == DEV_SLEEP);
      lockout_out <= lockout;
    end
  end
endmodule

// ---- rtl/flash_host.sv ----
// Purpose: host controller: AHB-Lite registers drive one- or two-byte flash frames
// Assumes: one master, whole-word single transfers, zero wait states
// Notes: commands while unpowered or asleep-but-not-wake are refused; commands during a frame are dropped unflagged
module flash_host
  import flash_pkg::*;
#(
  parameter int SCLK_HALF = SCLK_HALF_DEF,
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF,
  parameter int VSL = VSL_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  flash_link_if.host link
);
  host_state_t state;
  logic s_miso;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] div;
  logic [31:0] vsl_cnt;
  logic [4:0] bits_left;
  logic [15:0] tx;
  logic [7:0] rx;
  logic [7:0] last_op;
  logic refused, asleep, powered;

  // return line passes two flops
  sync2 #(.W(1), .INIT(1'b1)) u_sync (
    .mclk_in(mclk_in),
    .rstn_in(rstn_in),
    .d_in(link.miso_line),
    .q_out(s_miso)
  );

  // bus decode
  wire addr_ok = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ) && (hsize_in == 3'b010);
  wire busy = (state != HOST_IDLE) || !powered;
  wire [7:0] new_op = hwdata_in[7:0];
  wire cmd_wr = wr_pend && (wr_addr == REG_CMD);
  wire cmd_ok = cmd_wr && !busy && (!asleep || (new_op == OP_WAKE));
  wire div_done = (div == 32'd0);
  wire [31:0] stat_word = {16'h0000, rx, 5'b00000, asleep, refused, busy};

  // address phase capture and read data
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata_out <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      wr_pend <= addr_ok && hwrite_in;
      wr_addr <= haddr_in[7:0];
      if (addr_ok && !hwrite_in) begin
        hrdata_out <= (haddr_in[7:0] == REG_STAT) ? stat_word :
                      (haddr_in[7:0] == REG_CMD) ? {24'h000000, last_op} : 32'h0000_0000;
      end
    end
  end

  // supply-to-select wait after reset
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      vsl_cnt <= 32'd0;
      powered <= 1'b0;
    end else if (!powered) begin
      vsl_cnt <= vsl_cnt + 32'd1;
      if (vsl_cnt == 32'(VSL - 1)) powered <= 1'b1;
    end
  end

  // frame engine: select low for whole frame, clock divided from mclk
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state <= HOST_IDLE;
      link.cs_n <= 1'b1;
      link.sclk <= 1'b0;
      link.mosi <= 1'b0;
      div <= 32'd0;
      bits_left <= 5'd0;
      tx <= 16'h0000;
      rx <= 8'h00;
      last_op <= 8'h00;
      refused <= 1'b0;
      asleep <= 1'b0;
    end else begin
      case (state)
        HOST_IDLE: begin
          if (cmd_ok) begin
            state <= HOST_SHIFT;
            refused <= 1'b0;
            last_op <= new_op;
            link.cs_n <= 1'b0;
            link.mosi <= new_op[7];
            tx <= {new_op[6:0], 9'h000};
            bits_left <= hwdata_in[CMD_READ_BIT] ? 5'd16 : 5'd8;
            div <= 32'(SCLK_HALF - 1);
          end else if (cmd_wr) begin
            refused <= 1'b1;
          end
        end
        HOST_SHIFT: begin
          if (!div_done) begin
            div <= div - 32'd1;
          end else if (!link.sclk) begin
            link.sclk <= 1'b1;
            div <= 32'(SCLK_HALF - 1);
          end else begin
            link.sclk <= 1'b0;
            rx <= {rx[6:0], s_miso};
            link.mosi <= tx[15];
            tx <= {tx[14:0], 1'b0};
            bits_left <= bits_left - 5'd1;
            div <= 32'(SCLK_HALF - 1);
            if (bits_left == 5'd1) state <= HOST_END;
          end
        end
        HOST_END: begin
          if (!div_done) begin
            div <= div - 32'd1;
          end else begin
            link.cs_n <= 1'b1;
            state <= HOST_GAP;
            if (last_op == OP_WAKE) begin
              div <= 32'(WAKE_CYCLES + DESEL_CYCLES);
              asleep <= 1'b0;
            end else begin
              div <= 32'(DESEL_CYCLES);
              if (last_op == OP_SLEEP) asleep <= 1'b1;
            end
          end
        end
        HOST_GAP: begin
          if (!div_done) div <= div - 32'd1;
          else state <= HOST_IDLE;
        end
        default: state <= HOST_IDLE;
      endcase
    end
  end
endmodule

// ---- tb/flash_link_assertions.sv ----
// Purpose: link and device-state checks for the host and device pair
// Assumes: one clock domain, asynchronous low reset
// Notes: device status outputs are watched beside the link pins
module flash_link_assertions #(
  parameter int ERASE_CYCLES = 1000,
  parameter int SLEEP_CYCLES = 40
) (
  input wire logic mclk_in,
  input wire logic rstn_in,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [2:0] protect_level_in,
  input wire logic cycle_active_out,
  input wire logic write_permit_out,
  input wire logic deep_sleep_out,
  input wire logic lockout_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] act_cnt;
  logic [15:0] high_cnt;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  // erase length and deselect time counters
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      act_cnt <= 16'h0;
      high_cnt <= 16'h0;
    end else begin
      act_cnt <= cycle_active_out ? act_cnt + 16'h1 : 16'h0;
      high_cnt <= !cs_n ? 16'h0 : ((high_cnt == 16'hffff) ? high_cnt : high_cnt + 16'h1);
    end
  end
  sequence s_sel_high;
    cs_n [*8];
  endsequence
  property p_idle_clock; cs_n |-> !sclk; endproperty
  a_idle_clock: assert property (p_idle_clock) else $error("clock moved while deselected");
  property p_mosi_hold; sclk && $past(sclk) |-> $stable(mosi); endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("data changed while clock high");
  property p_erase_len; $fell(cycle_active_out) |-> act_cnt == 16'(ERASE_CYCLES); endproperty
  a_erase_len: assert property (p_erase_len) else $error("erase cycle length wrong");
  property p_erase_permit; $rose(cycle_active_out) |-> $past(write_permit_out) || $past(write_permit_out, 2); endproperty
  a_erase_permit: assert property (p_erase_permit) else $error("erase started without permit");
  property p_erase_unprot; $rose(cycle_active_out) |-> $past(protect_level_in, 2) == 3'b000; endproperty
  a_erase_unprot: assert property (p_erase_unprot) else $error("erase started while protected");
  property p_permit_clear; $fell(cycle_active_out) |-> !write_permit_out; endproperty
  a_permit_clear: assert property (p_permit_clear) else $error("permit latch still set at erase end");
  property p_lockout; lockout_out |-> !write_permit_out && !cycle_active_out; endproperty
  a_lockout: assert property (p_lockout) else $error("write accepted during lockout");
  property p_sleep_erase; cycle_active_out |-> !deep_sleep_out; endproperty
  a_sleep_erase: assert property (p_sleep_erase) else $error("sleep while erasing");
  property p_sleep_delay; $rose(deep_sleep_out) |-> high_cnt >= 16'(SLEEP_CYCLES); endproperty
  a_sleep_delay: assert property (p_sleep_delay) else $error("sleep entered too early");
  property p_wake_desel; $fell(deep_sleep_out) |-> s_sel_high; endproperty
  a_wake_desel: assert property (p_wake_desel) else $error("selected during wake delay");
  property p_power_up;
    $rose(rstn_in) |-> !deep_sleep_out && !write_permit_out && !cycle_active_out && lockout_out;
  endproperty
  a_power_up: assert property (p_power_up) else $error("wrong state after reset");
endmodule

// ---- tb/testbench.sv ----
// Purpose: drives the host over its bus and judges the device across the link
// Assumes: short lockout and select delay parameters
// Notes: a monitor records the last frame seen on the wire
module testbench
  import flash_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_CMD = {24'h0, REG_CMD};
  localparam logic [31:0] A_STAT = {24'h0, REG_STAT};
  localparam logic [8:0] RD = 9'h100;
  logic mclk_in, rstn_in, hsel, hwrite, hreadyout, hresp, prog_we, sclk_q;
  logic cycle_active, write_permit, deep_sleep, lockout;
  logic [1:0] htrans, lock_sel;
  logic [2:0] hsize, protect_level;
  logic [31:0] haddr, hwdata, hrdata;
  logic [3:0] prog_addr, peek_addr;
  logic [7:0] prog_data, peek_data, lock_reg, mon_bits, last_bits;
  int mon_cnt = 0;
  int last_cnt = 0;
  int n_errors = 0;
  int num_checks = 0;
  int k;
  flash_link_if link ();
  flash_host #(.VSL(50)) i_flash_host (.mclk_in(mclk_in), .rstn_in(rstn_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hreadyout),
    .hreadyout_out(hreadyout), .hresp_out(hresp), .hrdata_out(hrdata), .link(link.host));
  flash_dev #(.LOCKOUT(200)) i_flash_dev (.mclk_in(mclk_in), .rstn_in(rstn_in), .link(link.dev),
    .protect_level_in(protect_level), .prog_we_in(prog_we), .prog_addr_in(prog_addr), .prog_data_in(prog_data),
    .peek_addr_in(peek_addr), .peek_data_out(peek_data), .lock_sel_in(lock_sel), .lock_reg_out(lock_reg),
    .cycle_active_out(cycle_active), .write_permit_out(write_permit), .deep_sleep_out(deep_sleep),
    .lockout_out(lockout));
  flash_link_assertions #(.ERASE_CYCLES(ERASE_CYCLES_DEF), .SLEEP_CYCLES(SLEEP_CYCLES_DEF))
    i_flash_link_assertions (.mclk_in(mclk_in), .rstn_in(rstn_in), .cs_n(link.cs_n), .sclk(link.sclk),
    .mosi(link.mosi), .protect_level_in(protect_level), .cycle_active_out(cycle_active),
    .write_permit_out(write_permit), .deep_sleep_out(deep_sleep), .lockout_out(lockout));
  // clock
  initial begin
    mclk_in = 1'b0;
    forever #2 mclk_in = ~mclk_in;
  end
  // wire monitor: bits at clock rise, frame closed by deselect
  always @(posedge mclk_in) begin
    sclk_q <= link.sclk;
    if (link.sclk && !sclk_q && !link.cs_n) begin
      mon_bits <= {mon_bits[6:0], link.mosi};
      mon_cnt <= mon_cnt + 1;
    end
    if (link.cs_n && mon_cnt != 0) begin
      last_bits <= mon_bits;
      last_cnt <= mon_cnt;
      mon_cnt <= 0;
    end
  end
  task finish_test;
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task fail_wait(input string what);
    n_errors++;
    $display("CHECK FAILED %s expected done seen timeout", what);
    finish_test;
  endtask
  // one single-word transfer: address phase, then data phase
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
    int n;
    @(posedge mclk_in);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= 3'b010;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
      if (n > 50) fail_wait("bus ready");
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    n = 0;
    do begin
      @(posedge mclk_in);
      n++;
      if (n > 50) fail_wait("bus ready");
    end while (hreadyout !== 1'b1);
    rd = hrdata;
    check("bus response", 32'h0, {31'h0, hresp});
  endtask
  task wait_idle(output logic [31:0] st);
    int n;
    n = 0;
    do begin
      ahb(1'b0, A_STAT, 32'h0, st);
      n++;
      if (n > 500) fail_wait("host busy");
    end while (st[HST_BUSY_BIT] !== 1'b0);
  endtask
  task host_cmd(input logic [8:0] c, output logic [31:0] st);
    logic [31:0] rd;
    ahb(1'b1, A_CMD, {23'h0, c}, rd);
    wait_idle(st);
  endtask
  task wait_sleep;
    for (k = 0; k < 300 && deep_sleep !== 1'b1; k++) @(posedge mclk_in);
    if (k == 300) fail_wait("deep sleep");
  endtask
  task s_power_up;
    logic [31:0] st;
    ahb(1'b0, A_STAT, 32'h0, st);
    check("host busy", 32'h1, {31'h0, st[HST_BUSY_BIT]});
    ahb(1'b0, 32'h10, 32'h0, st);
    check("unmapped read", 32'h0, st);
    check("dev flags", 32'h1, {28'h0, cycle_active, write_permit, deep_sleep, lockout});
    for (int i = 0; i < 16; i++) begin
      peek_addr <= i[3:0];
      lock_sel <= i[1:0];
      repeat (2) @(posedge mclk_in);
      check("array byte", 32'hff, {24'h0, peek_data});
      check("lock reg", 32'h0, {24'h0, lock_reg});
    end
    wait_idle(st);
  endtask
  task s_lockout;
    logic [31:0] st;
    protect_level <= 3'b101;
    host_cmd({1'b0, OP_WRITE_PERMIT}, st);
    check("permit in lockout", 32'h0, {31'h0, write_permit});
    host_cmd(RD | {1'b0, OP_STATUS_READ}, st);
    check("status byte", 32'h14, {24'h0, st[HST_RX_LSB +: 8]});
    for (k = 0; k < 500 && lockout !== 1'b0; k++) @(posedge mclk_in);
    check("lockout end", 32'h0, {31'h0, lockout});
  endtask
  task s_refusals;
    logic [31:0] st;
    host_cmd({1'b0, OP_ARRAY_ERASE}, st);
    check("erase no permit", 32'h0, {31'h0, cycle_active});
    host_cmd({1'b0, OP_WRITE_PERMIT}, st);
    check("permit set", 32'h1, {31'h0, write_permit});
    host_cmd({1'b0, OP_ARRAY_ERASE}, st);
    check("erase protected", 32'h1, {30'h0, cycle_active, write_permit});
    protect_level <= 3'b000;
    host_cmd(RD | {1'b0, OP_ARRAY_ERASE}, st);
    check("erase long frame", 32'h1, {30'h0, cycle_active, write_permit});
    check("long frame bits", 32'd16, 32'(last_cnt));
  endtask
  task s_erase;
    logic [31:0] st;
    @(posedge mclk_in);
    prog_we <= 1'b1;
    prog_addr <= 4'h3;
    prog_data <= 8'h5a;
    peek_addr <= 4'h3;
    @(posedge mclk_in);
    prog_we <= 1'b0;
    repeat (2) @(posedge mclk_in);
    check("programmed byte", 32'h5a, {24'h0, peek_data});
    host_cmd({1'b0, OP_ARRAY_ERASE}, st);
    check("wire byte", {24'h0, OP_ARRAY_ERASE}, {24'h0, last_bits});
    ahb(1'b0, A_CMD, 32'h0, st);
    check("last op", {24'h0, OP_ARRAY_ERASE}, st);
    check("wire bits", 32'd8, 32'(last_cnt));
    check("erase running", 32'h2, {30'h0, cycle_active, write_permit});
    host_cmd(RD | {1'b0, OP_STATUS_READ}, st);
    check("status in erase", 32'h01, {24'h0, st[HST_RX_LSB +: 8]});
    host_cmd({1'b0, OP_SLEEP}, st);
    repeat (60) @(posedge mclk_in);
    check("sleep in erase", 32'h1, {30'h0, deep_sleep, cycle_active});
    host_cmd({1'b0, OP_WAKE}, st);
    check("wake in erase", 32'h1, {30'h0, deep_sleep, cycle_active});
    for (k = 0; k < 2000 && cycle_active !== 1'b0; k++) @(posedge mclk_in);
    if (k == 2000) fail_wait("erase end");
    repeat (2) @(posedge mclk_in);
    check("erased byte", 32'hff, {24'h0, peek_data});
    check("after erase", 32'h0, {30'h0, deep_sleep, write_permit});
  endtask
  task s_sleep;
    logic [31:0] st;
    host_cmd({1'b0, OP_SLEEP}, st);
    check("sleep early", 32'h0, {31'h0, deep_sleep});
    wait_sleep;
    host_cmd({1'b0, OP_WRITE_PERMIT}, st);
    check("refused asleep", 32'h1, {31'h0, st[HST_REFUSED_BIT]});
    check("permit asleep", 32'h0, {31'h0, write_permit});
    host_cmd(RD | {1'b0, OP_WAKE}, st);
    check("long wake", 32'h1, {31'h0, deep_sleep});
    check("long wake bits", 32'd16, 32'(last_cnt));
    host_cmd({1'b0, OP_WAKE}, st);
    check("woken", 32'h0, {31'h0, deep_sleep});
    host_cmd(RD | {1'b0, OP_STATUS_READ}, st);
    check("status after wake", 32'h0, {24'h0, st[HST_RX_LSB +: 8]});
  endtask
  task s_reset_mid;
    logic [31:0] st;
    host_cmd({1'b0, OP_WRITE_PERMIT}, st);
    host_cmd({1'b0, OP_SLEEP}, st);
    wait_sleep;
    @(posedge mclk_in);
    rstn_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    check("in reset", 32'h3, {28'h0, cycle_active, write_permit, deep_sleep, lockout, link.cs_n});
    rstn_in <= 1'b1;
    wait_idle(st);
    check("after reset", 32'h1, {28'h0, cycle_active, write_permit, deep_sleep, lockout});
  endtask
  // main sequence
  initial begin
    rstn_in = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    protect_level = 3'b000;
    prog_we = 1'b0;
    prog_addr = 4'h0;
    prog_data = 8'hff;
    peek_addr = 4'h0;
    lock_sel = 2'b00;
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    s_power_up;
    s_lockout;
    s_refusals;
    s_erase;
    s_sleep;
    s_reset_mid;
    finish_test;
  end
endmodule
